/* rtl/aie_consts.svh */
// Named constants for the aggregated interrupt expander.
// Assumes inclusion by bare name from files under rtl/.
`ifndef AIE_CONSTS_SVH
`define AIE_CONSTS_SVH

// ****************************************
// Register pointers on the two-wire port
// ****************************************
`define AIE_REG_FLAGS 8'h00
`define AIE_REG_ENABLE 8'h01
`define AIE_REG_PENDING 8'h02

// ****************************************
// Reset values and link constants
// ****************************************
`define AIE_ENABLE_RST 8'h00
`define AIE_FLAGS_RST 8'h00
`define AIE_UNMAPPED_READ 8'h00
`define AIE_TARGET_ADDR 7'h2a
`define AIE_CNT_ZERO 4'h0
`define AIE_CNT_ONE 4'h1
`define AIE_CNT_BYTE 4'h8
`define AIE_PTR_STEP 8'h01

`endif

/* rtl/aie_pkg.sv */
// Types shared by the aggregated interrupt expander.
// Assumes no other package is needed.
package aie_pkg;

   // ****************************************
   // Two-wire target sequencer states
   // ****************************************
   typedef enum logic [6:0] {
      AIE_IDLE  = 7'b0000001,
      AIE_ADDR  = 7'b0000010,
      AIE_PTR   = 7'b0000100,
      AIE_WDATA = 7'b0001000,
      AIE_ACK   = 7'b0010000,
      AIE_RDATA = 7'b0100000,
      AIE_RACK  = 7'b1000000
   } aie_state_t;

endpackage

/* rtl/aie_sync.sv */
// Two-flop synchroniser for levels arriving from outside sys_clk.
// Assumes the input changes slowly compared with the clock.
`timescale 1ns/100ps
`default_nettype none

module aie_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   // Asynchronous level in, synchronised level out.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // The first stage feeds only the second stage.
   always_comb begin
      meta_next = ce ? d : meta_reg;
      q_next = ce ? meta_reg : q_reg;
   end

   // Reset to the idle level of the line so no false edge follows reset.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         meta_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         meta_reg <= meta_next;
         q_reg <= q_next;
      end
   end

   assign q = q_reg;

endmodule
`default_nettype wire

/* rtl/aie_top.sv */
// Interrupt aggregation with a two-wire target port for flags and enables.
// Assumes internal events are one-cycle pulses on sys_clk and external
// event lines and the bus pins are asynchronous levels.
`timescale 1ns/100ps
`default_nettype none
`include "aie_consts.svh"

module aie_top
   import aie_pkg::*;
#(
   parameter int INT_SRC = 3,
   parameter int EXT_SRC = 2,
   parameter logic [6:0] TARGET_ADDR = `AIE_TARGET_ADDR
) (
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   // Event sources: internal pulses, external asynchronous levels.
   input wire logic [INT_SRC-1:0] int_evt,
   input wire logic [EXT_SRC-1:0] ext_evt,
   // Two-wire target pins; data line is open drain.
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Interrupt request to the host.
   output logic irq_out
);

   localparam int NSRC = INT_SRC + EXT_SRC;

   // ****************************************
   // Input synchronisation
   // ****************************************
   logic [1:0] bus_s;
   logic [EXT_SRC-1:0] ext_s;
   logic scl_s;
   logic sda_s;

   aie_sync #(.W(2), .RST_VAL(2'b11)) u_bus_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .d({scl_in, sda_in}),
      .q(bus_s)
   );

   aie_sync #(.W(EXT_SRC), .RST_VAL('0)) u_ext_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .ce(ce),
      .d(ext_evt),
      .q(ext_s)
   );

   assign scl_s = bus_s[1];
   assign sda_s = bus_s[0];

   // ****************************************
   // Line edge detection
   // ****************************************
   logic scl_d_reg;
   logic scl_d_next;
   logic sda_d_reg;
   logic sda_d_next;
   logic [EXT_SRC-1:0] ext_d_reg;
   logic [EXT_SRC-1:0] ext_d_next;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic [EXT_SRC-1:0] ext_rise;

   // Delayed copies for edges; start and stop need scl held high.
   always_comb begin
      scl_d_next = ce ? scl_s : scl_d_reg;
      sda_d_next = ce ? sda_s : sda_d_reg;
      ext_d_next = ce ? ext_s : ext_d_reg;
      scl_rise = scl_s & ~scl_d_reg;
      scl_fall = ~scl_s & scl_d_reg;
      bus_start = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
      bus_stop = scl_s & scl_d_reg & sda_s & ~sda_d_reg;
      ext_rise = ext_s & ~ext_d_reg;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         ext_d_reg <= '0;
      end else begin
         scl_d_reg <= scl_d_next;
         sda_d_reg <= sda_d_next;
         ext_d_reg <= ext_d_next;
      end
   end

   // ****************************************
   // Interrupt state
   // ****************************************
   logic [NSRC-1:0] flags_reg;
   logic [NSRC-1:0] flags_next;
   logic [NSRC-1:0] enable_reg;
   logic [NSRC-1:0] enable_next;
   logic irq_reg;
   logic irq_next;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;

   // Register read view; unmapped pointers read as zero.
   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      logic [7:0] r;
      r = `AIE_UNMAPPED_READ;
      case (a)
         `AIE_REG_FLAGS: r[NSRC-1:0] = flags_reg;
         `AIE_REG_ENABLE: r[NSRC-1:0] = enable_reg;
         `AIE_REG_PENDING: r[NSRC-1:0] = flags_reg & enable_reg;
         default: r = `AIE_UNMAPPED_READ;
      endcase
      return r;
   endfunction

   // Events latch only when enabled; a new event beats a same-cycle clear,
   // so no event is lost while the host is acknowledging another.
   always_comb begin
      logic [NSRC-1:0] set;
      logic [NSRC-1:0] clr;
      set = {ext_rise, int_evt} & enable_reg;
      clr = '0;
      enable_next = enable_reg;
      if (wr_en && (wr_addr == `AIE_REG_FLAGS)) begin
         clr = wr_data[NSRC-1:0];
      end
      if (wr_en && (wr_addr == `AIE_REG_ENABLE)) begin
         enable_next = wr_data[NSRC-1:0];
      end
      flags_next = (flags_reg & ~clr) | set;
      irq_next = |(flags_next & enable_next);
      if (!ce) begin
         flags_next = flags_reg;
         enable_next = enable_reg;
         irq_next = irq_reg;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         flags_reg <= NSRC'(`AIE_FLAGS_RST);
         enable_reg <= NSRC'(`AIE_ENABLE_RST);
         irq_reg <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         enable_reg <= enable_next;
         irq_reg <= irq_next;
      end
   end

   assign irq_out = irq_reg;

   // ****************************************
   // Two-wire target sequencer
   // ****************************************
   aie_state_t state_reg;
   aie_state_t state_next;
   aie_state_t after_reg;
   aie_state_t after_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [7:0] ptr_reg;
   logic [7:0] ptr_next;
   logic oe_n_reg;
   logic oe_n_next;
   logic nack_reg;
   logic nack_next;

   // Bits are sampled on scl rise and driven on scl fall; start or stop
   // aborts any transfer, which is the only access path to the registers.
   always_comb begin
      logic [7:0] tx;
      tx = rd_byte(ptr_reg);
      state_next = state_reg;
      after_next = after_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      oe_n_next = oe_n_reg;
      nack_next = nack_reg;
      wr_en = 1'b0;
      wr_addr = ptr_reg;
      wr_data = shift_reg;
      if (!ce) begin
         wr_en = 1'b0;
      end else if (bus_start) begin
         state_next = AIE_ADDR;
         cnt_next = `AIE_CNT_ZERO;
         oe_n_next = 1'b1;
      end else if (bus_stop) begin
         state_next = AIE_IDLE;
         oe_n_next = 1'b1;
      end else begin
         case (state_reg)
            AIE_ADDR, AIE_PTR, AIE_WDATA: begin
               if (scl_rise && (cnt_reg != `AIE_CNT_BYTE)) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  cnt_next = 4'(cnt_reg + `AIE_CNT_ONE);
               end else if (scl_fall && (cnt_reg == `AIE_CNT_BYTE)) begin
                  oe_n_next = 1'b0;
                  state_next = AIE_ACK;
                  if (state_reg == AIE_ADDR) begin
                     if (shift_reg[7:1] != TARGET_ADDR) begin
                        oe_n_next = 1'b1;
                        state_next = AIE_IDLE;
                     end else if (shift_reg[0]) begin
                        after_next = AIE_RDATA;
                     end else begin
                        after_next = AIE_PTR;
                     end
                  end else if (state_reg == AIE_PTR) begin
                     ptr_next = shift_reg;
                     after_next = AIE_WDATA;
                  end else begin
                     wr_en = 1'b1;
                     ptr_next = 8'(ptr_reg + `AIE_PTR_STEP);
                     after_next = AIE_WDATA;
                  end
               end
            end
            AIE_ACK: begin
               if (scl_fall) begin
                  state_next = after_reg;
                  cnt_next = `AIE_CNT_ZERO;
                  oe_n_next = 1'b1;
                  if (after_reg == AIE_RDATA) begin
                     shift_next = tx;
                     oe_n_next = tx[7];
                     cnt_next = `AIE_CNT_ONE;
                  end
               end
            end
            AIE_RDATA: begin
               if (scl_fall) begin
                  if (cnt_reg == `AIE_CNT_BYTE) begin
                     oe_n_next = 1'b1;
                     state_next = AIE_RACK;
                  end else begin
                     oe_n_next = shift_reg[6];
                     shift_next = {shift_reg[6:0], 1'b0};
                     cnt_next = 4'(cnt_reg + `AIE_CNT_ONE);
                  end
               end
            end
            AIE_RACK: begin
               if (scl_rise) begin
                  nack_next = sda_s;
               end else if (scl_fall) begin
                  if (nack_reg) begin
                     state_next = AIE_IDLE;
                  end else begin
                     // Reading never clears a flag; only a write does.
                     ptr_next = 8'(ptr_reg + `AIE_PTR_STEP);
                     tx = rd_byte(8'(ptr_reg + `AIE_PTR_STEP));
                     shift_next = tx;
                     oe_n_next = tx[7];
                     cnt_next = `AIE_CNT_ONE;
                     state_next = AIE_RDATA;
                  end
               end
            end
            AIE_IDLE: begin
               oe_n_next = 1'b1;
            end
            default: begin
               state_next = AIE_IDLE;
               oe_n_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= AIE_IDLE;
         after_reg <= AIE_IDLE;
         cnt_reg <= `AIE_CNT_ZERO;
         shift_reg <= `AIE_UNMAPPED_READ;
         ptr_reg <= `AIE_REG_FLAGS;
         oe_n_reg <= 1'b1;
         nack_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         after_reg <= after_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         oe_n_reg <= oe_n_next;
         nack_reg <= nack_next;
      end
   end

   // Open drain: the line is only ever pulled low.
   assign sda_out = 1'b0;
   assign sda_oe_n = oe_n_reg;

endmodule
`default_nettype wire

/* verification/aie_top_assertions.sv */
// Port checker for the interrupt expander, bound to aie_top.
// Assumes ce is low only while the bus is idle and the host half period
// is eight cycles.
`timescale 1ns/100ps
`default_nettype none
module aie_top_assertions #(
   parameter int INT_SRC = 3,
   parameter int EXT_SRC = 2
) (
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ce,
   // Event sources.
   input wire logic [INT_SRC-1:0] int_evt,
   input wire logic [EXT_SRC-1:0] ext_evt,
   // Bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // Request.
   input wire logic irq_out
);
   // ****
   // Quiet-cycle counters
   // ****
   logic [4:0] scl_cnt_reg;
   logic [4:0] act_cnt_reg;
   logic [EXT_SRC-1:0] ext_reg;
   logic seen_reg;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // Counters saturate, so long idle spans cost nothing.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         scl_cnt_reg <= 5'h1f;
         act_cnt_reg <= 5'h1f;
         ext_reg <= '0;
         seen_reg <= 1'b0;
      end else begin
         ext_reg <= ext_evt;
         seen_reg <= seen_reg | !scl_in;
         if (!scl_in) begin
            scl_cnt_reg <= 5'h00;
         end else if (scl_cnt_reg != 5'h1f) begin
            scl_cnt_reg <= scl_cnt_reg + 5'h01;
         end
         if (!scl_in || int_evt != '0 || ext_evt != ext_reg) begin
            act_cnt_reg <= 5'h00;
         end else if (act_cnt_reg != 5'h1f) begin
            act_cnt_reg <= act_cnt_reg + 5'h01;
         end
      end
   end
   // ****
   // Properties
   // ****
   property p_quiet;
      $past(reset) |-> !irq_out && sda_oe_n;
   endproperty
   a_quiet: assert property (p_quiet) else $error("busy after reset");
   property p_no_bus;
      !seen_reg |-> !irq_out;
   endproperty
   a_no_bus: assert property (p_no_bus) else $error("irq unenabled");
   property p_rise;
      $rose(irq_out) |-> act_cnt_reg < 5'h08;
   endproperty
   a_rise: assert property (p_rise) else $error("irq without cause");
   property p_hold;
      irq_out && scl_cnt_reg > 5'h18 |=> irq_out;
   endproperty
   a_hold: assert property (p_hold) else $error("irq dropped idle");
   property p_fall;
      $fell(irq_out) |-> scl_cnt_reg < 5'h08;
   endproperty
   a_fall: assert property (p_fall) else $error("irq fell no clear");
   property p_od;
      sda_out == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("data driven high");
   // The target may only move the data line while the bus clock is low.
   property p_edge;
      $changed(sda_oe_n) |-> scl_cnt_reg < 5'h08;
   endproperty
   a_edge: assert property (p_edge) else $error("data moved clock high");
   property p_oe;
      scl_cnt_reg > 5'h18 |-> sda_oe_n;
   endproperty
   a_oe: assert property (p_oe) else $error("data pulled idle");
endmodule
bind aie_top aie_top_assertions #(.INT_SRC(INT_SRC), .EXT_SRC(EXT_SRC)) i_chk (
   .sys_clk(sys_clk), .reset(reset), .ce(ce), .int_evt(int_evt),
   .ext_evt(ext_evt), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .irq_out(irq_out));
`default_nettype wire

/* verification/aie_host_model.sv */
// Host model: a two-wire controller reading and clearing flags.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module aie_host_model (
   // Clock.
   input wire logic sys_clk,
   // Bus lines; sda_low pulls data down.
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // ****
   // Bus cycles
   // ****
   // Bus clock stands high outside frames.
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Eight cycles a phase covers the target's sync delay.
   task automatic wt();
      repeat (8) @(posedge sys_clk);
   endtask
   // Start, also serving as repeated start.
   task automatic start();
      @(posedge sys_clk);
      sda_low <= 1'b0;
      wt();
      scl <= 1'b1;
      wt();
      sda_low <= 1'b1;
      wt();
      scl <= 1'b0;
   endtask
   task automatic stop();
      @(posedge sys_clk);
      sda_low <= 1'b1;
      wt();
      scl <= 1'b1;
      wt();
      sda_low <= 1'b0;
      wt();
   endtask
   // One bit each way, sampled at the end of the high phase.
   task automatic bit_io(input logic b, output logic r);
      @(posedge sys_clk);
      sda_low <= !b;
      wt();
      scl <= 1'b1;
      wt();
      r = sda;
      scl <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] w, input logic mack,
                       output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(w[i], r[i]);
      end
      bit_io(!mack, a);
      ack = !a;
   endtask
   task automatic wr_reg(input logic [7:0] p, input logic [7:0] d,
                         output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      start();
      xfer(8'h54, 1'b0, r, a0);
      xfer(p, 1'b0, r, a1);
      xfer(d, 1'b0, r, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] p,
                         output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic a0, a1, a2, n;
      start();
      xfer({a, 1'b0}, 1'b0, r, a0);
      xfer(p, 1'b0, r, a1);
      start();
      xfer({a, 1'b1}, 1'b0, r, a2);
      xfer(8'hff, 1'b0, d, n);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
// Bench for aie_top: events in, host model reading and clearing flags.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic sys_clk;
   logic reset;
   logic ce;
   logic [2:0] int_evt;
   logic [1:0] ext_evt;
   logic scl;
   logic m_low;
   logic sda_out;
   logic sda_oe_n;
   logic irq_out;
   wire logic sda;
   logic [7:0] d;
   logic ok;
   int bad_count;
   int tests_run;
   // Open-drain data line with a pull-up.
   assign sda = (m_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
   aie_top i_aie_top (.sys_clk(sys_clk), .reset(reset), .ce(ce),
      .int_evt(int_evt), .ext_evt(ext_evt), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq_out(irq_out));
   aie_host_model i_aie_host_model (.sys_clk(sys_clk), .scl(scl),
      .sda_low(m_low), .sda(sda));
   // ****
   // Helpers
   // ****
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] exp);
      i_aie_host_model.rd_reg(7'h2a, p, d, ok);
      check({7'h0, ok}, 8'h01);
      check(d, exp);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      i_aie_host_model.wr_reg(p, v, ok);
      check({7'h0, ok}, 8'h01);
   endtask
   // Sources 0..2 pulse for one cycle; 3..4 are external rising edges.
   task automatic fire(input int i);
      @(posedge sys_clk);
      if (i < 3) begin
         int_evt <= 3'h1 << i;
      end else begin
         ext_evt <= 2'h1 << (i - 3);
      end
      @(posedge sys_clk);
      int_evt <= '0;
      repeat (6) @(posedge sys_clk);
      ext_evt <= '0;
      repeat (6) @(posedge sys_clk);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_disabled();
      for (int i = 0; i < 5; i++) begin
         fire(i);
      end
      check({7'h0, irq_out}, 8'h00);
      rd(8'h01, 8'h00);
      rd(8'h00, 8'h00);
   endtask
   task automatic t_each();
      wr(8'h01, 8'h1f);
      rd(8'h01, 8'h1f);
      for (int i = 0; i < 5; i++) begin
         fire(i);
         check({7'h0, irq_out}, 8'h01);
         rd(8'h00, 8'h01 << i);
         rd(8'h00, 8'h01 << i);
         check({7'h0, irq_out}, 8'h01);
         wr(8'h00, 8'h01 << i);
         check({7'h0, irq_out}, 8'h00);
      end
   endtask
   task automatic t_multi();
      fire(0);
      fire(4);
      wr(8'h00, 8'h01);
      check({7'h0, irq_out}, 8'h01);
      rd(8'h02, 8'h10);
      wr(8'h01, 8'h0f);
      check({7'h0, irq_out}, 8'h00);
      rd(8'h00, 8'h10);
      wr(8'h01, 8'h1f);
      check({7'h0, irq_out}, 8'h01);
      wr(8'h00, 8'h10);
      check({7'h0, irq_out}, 8'h00);
   endtask
   // A mid-run reset must drop the request and the enables; a pulse seen
   // while ce is low must leave no flag behind.
   task automatic t_reset();
      fire(2);
      check({7'h0, irq_out}, 8'h01);
      reset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check({7'h0, irq_out}, 8'h00);
      rd(8'h01, 8'h00);
      rd(8'h00, 8'h00);
      wr(8'h01, 8'h1f);
      ce <= 1'b0;
      fire(1);
      ce <= 1'b1;
      @(posedge sys_clk);
      check({7'h0, irq_out}, 8'h00);
      rd(8'h00, 8'h00);
   endtask
   task automatic t_bad();
      i_aie_host_model.rd_reg(7'h15, 8'h00, d, ok);
      check({7'h0, ok}, 8'h00);
      rd(8'h05, 8'h00);
   endtask
   // ****
   // Clock, sequence, watchdog
   // ****
   initial begin
      sys_clk = 1'b0;
      forever begin
         #12.5 sys_clk = !sys_clk;
      end
   end
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      int_evt = '0;
      ext_evt = '0;
      bad_count = 0;
      tests_run = 0;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      t_disabled();
      t_each();
      t_multi();
      t_reset();
      t_bad();
      tally_and_finish();
   end
   // About three times the expected run, so a hang is cut short.
   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
